/* File: design/optical_pkg.sv */
// Purpose: shared constants and types for the optical port and pulse shaper
// Assumes: 200 MHz system clock, 8-bit register port with 16-bit addresses
// Notes: status register offset and base time unit are local choices
package optical_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  localparam logic [15:0] PLS_CTL_ADDR = 16'h2004;
  localparam logic [15:0] TX_CFG_ADDR = 16'h2007;
  localparam logic [15:0] OPT_CTL_ADDR = 16'h2008;
  localparam logic [15:0] WIDTH_ADDR = 16'h2080;
  localparam logic [15:0] UNIT_ADDR = 16'h2081;
  localparam logic [15:0] STATUS_ADDR = 16'h2082;

  localparam int DUTY_LSB = 0;
  localparam int SRC_LSB = 6;
  localparam int TXINV_BIT = 0;
  localparam int TXMOD_BIT = 1;
  localparam int RXINV_BIT = 4;
  localparam int RXROLE_BIT = 5;
  localparam int POL_BIT = 6;

  localparam logic [1:0] DUTY_RESET = 2'h0;
  localparam logic [1:0] SRC_RESET = 2'h0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [7:0] WIDTH_RESET = 8'hff;
  localparam logic [7:0] UNIT_RESET = 8'h00;
  localparam logic [7:0] WIDTH_NO_LIMIT = 8'hff;
  localparam logic [7:0] UNIT_USE_SAMPLE = 8'h00;
  localparam logic [7:0] FIFO_INTERVAL = 8'h51;

  localparam int CLK_PERIOD_PS = 5000;
  localparam int SAMPLE_TIME_US = 397;
  localparam int SAMPLE_CYCLES = (SAMPLE_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int UNIT_TIME_US = 1;
  localparam int UNIT_CYCLES = (UNIT_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int CARRIER_CYCLES = 64;
  localparam int PEND_DEPTH = 4;

  typedef enum logic [1:0] {
    SRC_UART,
    SRC_PIN_TWO,
    SRC_REAL,
    SRC_REACTIVE
  } tx_source_type;

  typedef enum logic [1:0] {
    SHAPE_IDLE,
    SHAPE_ACTIVE,
    SHAPE_GAP
  } shape_state_type;

  typedef struct packed {
    logic [1:0] duty;
    tx_source_type source;
    logic tx_invert;
    logic tx_modulate;
    logic rx_invert;
    logic rx_role;
    logic polarity;
    logic [7:0] width_limit;
    logic [7:0] time_unit;
  } optical_cfg_type;

  typedef struct packed {
    logic [7:0] width_limit;
    logic fifo_mode;
    logic unit_tick;
  } shaper_ctl_type;

endpackage : optical_pkg

/* File: design/tx_carrier_gen.sv */
// Purpose: free-running modulation carrier with selectable low fraction
// Assumes: period is a power of two of at least 16 cycles
// Notes: output is 0 during the low part of each carrier period
`timescale 1ns/1ps
module tx_carrier_gen #(
  parameter int PERIOD = optical_pkg::CARRIER_CYCLES
) (
  input wire logic clk,         // system clock
  input wire logic rst,         // synchronous reset
  input wire logic [1:0] duty,  // low fraction select
  output logic carrier_reg      // carrier level
);
  localparam int CW = $clog2(PERIOD);

  logic [CW-1:0] count_reg;
  logic [CW:0] low_len;

  if (PERIOD < 16 || (PERIOD & (PERIOD - 1)) != 0) begin : g_check
    $error("carrier period must be a power of two of at least 16");
  end

  always_comb begin
    // shift amount widened so duty 3 does not wrap to a shift of zero
    low_len = (CW + 1)'(PERIOD) >> ({1'b0, duty} + 3'h1);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      carrier_reg <= 1'b1;
    end else begin
      carrier_reg <= ({1'b0, count_reg} >= low_len);
    end
  end

endmodule : tx_carrier_gen

/* File: design/pulse_shaper.sv */
// Purpose: width limit and spacing for one energy pulse channel
// Assumes: fire is one cycle per issued pulse, unit_tick one cycle per unit
// Notes: in bypass mode a pulse that arrives while active restarts it
`timescale 1ns/1ps
module pulse_shaper #(
  parameter int DEPTH = optical_pkg::PEND_DEPTH
) (
  input wire logic clk,                        // system clock
  input wire logic rst,                        // synchronous reset
  input wire logic fire,                       // pulse issued
  input wire optical_pkg::shaper_ctl_type ctl, // width, mode, tick
  output logic active_reg                      // pulse asserted
);
  localparam int PW = $clog2(DEPTH + 1);

  optical_pkg::shape_state_type state_reg, state_next;
  logic [8:0] span_reg;
  logic [PW-1:0] pend_reg;
  logic free_run;
  logic start;
  logic [8:0] limit;

  if (DEPTH < 1 || DEPTH > 255) begin : g_check
    $error("pending depth must be 1 to 255");
  end

  always_comb begin
    free_run = (ctl.width_limit == optical_pkg::WIDTH_NO_LIMIT);
    limit = {ctl.width_limit, 1'b1};
    start = (state_reg == optical_pkg::SHAPE_IDLE) && !free_run
            && (ctl.fifo_mode ? (pend_reg != '0) : fire);
    state_next = state_reg;
    case (state_reg)
      optical_pkg::SHAPE_IDLE: begin
        if (start) begin
          state_next = optical_pkg::SHAPE_ACTIVE;
        end
      end
      optical_pkg::SHAPE_ACTIVE: begin
        // width limit
        // a bypass restart in the ending cycle keeps the pulse active
        if (ctl.unit_tick && !(fire && !ctl.fifo_mode) && (span_reg + 9'h001 >= limit)) begin
          state_next = ctl.fifo_mode ? optical_pkg::SHAPE_GAP : optical_pkg::SHAPE_IDLE;
        end
      end
      default: begin
        if (ctl.unit_tick) begin
          state_next = optical_pkg::SHAPE_IDLE;
        end
      end
    endcase
    if (free_run) begin
      state_next = optical_pkg::SHAPE_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= optical_pkg::SHAPE_IDLE;
      span_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (start || (fire && !ctl.fifo_mode)) begin
        span_reg <= '0;
      end else if (ctl.unit_tick) begin
        span_reg <= span_reg + 9'h001;
      end
    end
  end

  // pending count only in fifo mode
  always_ff @(posedge clk) begin
    if (rst || !ctl.fifo_mode || free_run) begin
      pend_reg <= '0;
    end else if (fire && !start && pend_reg != PW'(DEPTH)) begin
      pend_reg <= pend_reg + 1'b1;
    end else if (start && !fire) begin
      pend_reg <= pend_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      active_reg <= 1'b0;
    end else if (free_run) begin
      active_reg <= active_reg ^ fire;
    end else begin
      active_reg <= (state_next == optical_pkg::SHAPE_ACTIVE);
    end
  end

endmodule : pulse_shaper

/* File: design/optical_port.sv */
// Purpose: optical port pin conditioning and energy pulse output shaping
// Assumes: all inputs synchronous to clk, register port with 1-cycle read
// Notes: pulse pins and transmit pin are registered outputs
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module optical_port #(
  parameter int SAMPLE_CYCLES = optical_pkg::SAMPLE_CYCLES,
  parameter int CARRIER_PERIOD = optical_pkg::CARRIER_CYCLES,
  parameter int PEND_DEPTH = optical_pkg::PEND_DEPTH
) (
  input wire logic clk,                  // system clock
  input wire logic rst,                  // synchronous reset
  input wire logic [15:0] addr,          // register address
  input wire logic [7:0] wr_data,        // register write data
  input wire logic wr_en,                // write strobe
  input wire logic rd_en,                // read strobe
  output logic [7:0] rd_data,            // read data, cycle after rd_en
  input wire logic uart_tx_data,         // optical uart transmit
  input wire logic general_pin_two_out,  // pin two output level
  input wire logic real_pulse_req,       // real-energy pulse issued
  input wire logic reactive_pulse_req,   // reactive-energy pulse issued
  input wire logic ir_rx_comparator,     // comparator result of receive pin
  input wire logic ir_receive_pin_level, // digital level of receive pin
  output logic ir_transmit_pin,          // optical transmit pin
  output logic real_energy_pulse,        // real-energy pulse pin
  output logic reactive_energy_pulse,    // reactive-energy pulse pin
  output logic uart_rx_data,             // optical uart receive
  output logic general_pin_one_in        // pin one input level
);
  localparam int UNIT_CYCLES = optical_pkg::UNIT_CYCLES;

  optical_pkg::optical_cfg_type cfg_reg;
  logic [$clog2(SAMPLE_CYCLES)-1:0] sample_cnt_reg;
  logic [$clog2(UNIT_CYCLES)-1:0] base_cnt_reg;
  logic [7:0] unit_cnt_reg;
  logic sample_tick;
  logic base_tick;
  logic unit_tick_reg;
  logic fifo_mode;
  optical_pkg::shaper_ctl_type shaper_ctl;
  logic real_active;
  logic reactive_active;
  logic carrier;
  logic tx_src;
  logic tx_inv;
  logic tx_next;
  logic [7:0] rd_next;
  logic [7:0] status;
  logic ir_transmit_pin_reg;
  logic real_energy_pulse_reg;
  logic reactive_energy_pulse_reg;
  logic uart_rx_data_reg;
  logic general_pin_one_in_reg;
  logic [7:0] rd_data_reg;

  if (SAMPLE_CYCLES < 2 || UNIT_CYCLES < 2) begin : g_check
    $error("sample and unit counts must be at least 2");
  end

  // register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg.duty <= optical_pkg::DUTY_RESET;
      cfg_reg.source <= optical_pkg::tx_source_type'(optical_pkg::SRC_RESET);
      cfg_reg.tx_invert <= optical_pkg::FLAG_RESET;
      cfg_reg.tx_modulate <= optical_pkg::FLAG_RESET;
      cfg_reg.rx_invert <= optical_pkg::FLAG_RESET;
      cfg_reg.rx_role <= optical_pkg::FLAG_RESET;
      cfg_reg.polarity <= optical_pkg::FLAG_RESET;
      cfg_reg.width_limit <= optical_pkg::WIDTH_RESET;
      cfg_reg.time_unit <= optical_pkg::UNIT_RESET;
    end else if (wr_en) begin
      if (addr == optical_pkg::PLS_CTL_ADDR) begin
        cfg_reg.polarity <= wr_data[optical_pkg::POL_BIT];
      end else if (addr == optical_pkg::TX_CFG_ADDR) begin
        cfg_reg.duty <= wr_data[optical_pkg::DUTY_LSB +: 2];
        cfg_reg.source <= optical_pkg::tx_source_type'(wr_data[optical_pkg::SRC_LSB +: 2]);
      end else if (addr == optical_pkg::OPT_CTL_ADDR) begin
        cfg_reg.tx_invert <= wr_data[optical_pkg::TXINV_BIT];
        cfg_reg.tx_modulate <= wr_data[optical_pkg::TXMOD_BIT];
        cfg_reg.rx_invert <= wr_data[optical_pkg::RXINV_BIT];
        cfg_reg.rx_role <= wr_data[optical_pkg::RXROLE_BIT];
      end else if (addr == optical_pkg::WIDTH_ADDR) begin
        cfg_reg.width_limit <= wr_data;
      end else if (addr == optical_pkg::UNIT_ADDR) begin
        cfg_reg.time_unit <= wr_data;
      end
    end
  end

  // read mux; unmapped addresses and reserved bits read as zero
  always_comb begin
    status = {3'h0, general_pin_one_in_reg, uart_rx_data_reg,
              reactive_energy_pulse_reg, real_energy_pulse_reg, ir_transmit_pin_reg};
    rd_next = 8'h00;
    if (addr == optical_pkg::PLS_CTL_ADDR) begin
      rd_next[optical_pkg::POL_BIT] = cfg_reg.polarity;
    end else if (addr == optical_pkg::TX_CFG_ADDR) begin
      rd_next[optical_pkg::DUTY_LSB +: 2] = cfg_reg.duty;
      rd_next[optical_pkg::SRC_LSB +: 2] = cfg_reg.source;
    end else if (addr == optical_pkg::OPT_CTL_ADDR) begin
      rd_next[optical_pkg::TXINV_BIT] = cfg_reg.tx_invert;
      rd_next[optical_pkg::TXMOD_BIT] = cfg_reg.tx_modulate;
      rd_next[optical_pkg::RXINV_BIT] = cfg_reg.rx_invert;
      rd_next[optical_pkg::RXROLE_BIT] = cfg_reg.rx_role;
    end else if (addr == optical_pkg::WIDTH_ADDR) begin
      rd_next = cfg_reg.width_limit;
    end else if (addr == optical_pkg::UNIT_ADDR) begin
      rd_next = cfg_reg.time_unit;
    end else if (addr == optical_pkg::STATUS_ADDR) begin
      rd_next = status;
    end
  end

  // data stand for one cycle only, zero otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= rd_en ? rd_next : 8'h00;
    end
  end

  // sample period counter runs free so the unit stays aligned to samples
  always_ff @(posedge clk) begin
    if (rst || sample_tick) begin
      sample_cnt_reg <= '0;
    end else begin
      sample_cnt_reg <= sample_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || base_tick) begin
      base_cnt_reg <= '0;
    end else begin
      base_cnt_reg <= base_cnt_reg + 1'b1;
    end
  end

  always_comb begin
    sample_tick = (sample_cnt_reg == ($clog2(SAMPLE_CYCLES))'(SAMPLE_CYCLES - 1));
    base_tick = (base_cnt_reg == ($clog2(UNIT_CYCLES))'(UNIT_CYCLES - 1));
    fifo_mode = (cfg_reg.time_unit != optical_pkg::UNIT_USE_SAMPLE);
  end

  // compare with >= so a lowered setting takes effect at once
  always_ff @(posedge clk) begin
    if (rst || !fifo_mode) begin
      unit_cnt_reg <= 8'h00;
    end else if (base_tick) begin
      if (unit_cnt_reg + 8'h01 >= cfg_reg.time_unit) begin
        unit_cnt_reg <= 8'h00;
      end else begin
        unit_cnt_reg <= unit_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      unit_tick_reg <= 1'b0;
    end else if (!fifo_mode) begin
      unit_tick_reg <= sample_tick;
    end else begin
      unit_tick_reg <= base_tick && (unit_cnt_reg + 8'h01 >= cfg_reg.time_unit);
    end
  end

  always_comb begin
    shaper_ctl.width_limit = cfg_reg.width_limit;
    shaper_ctl.fifo_mode = fifo_mode;
    shaper_ctl.unit_tick = unit_tick_reg;
  end

  pulse_shaper #(
    .DEPTH(PEND_DEPTH)
  ) real_shaper (
    .clk(clk),
    .rst(rst),
    .fire(real_pulse_req),
    .ctl(shaper_ctl),
    .active_reg(real_active)
  );

  pulse_shaper #(
    .DEPTH(PEND_DEPTH)
  ) reactive_shaper (
    .clk(clk),
    .rst(rst),
    .fire(reactive_pulse_req),
    .ctl(shaper_ctl),
    .active_reg(reactive_active)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      real_energy_pulse_reg <= 1'b1;
      reactive_energy_pulse_reg <= 1'b1;
    end else begin
      real_energy_pulse_reg <= cfg_reg.polarity ? real_active : !real_active;
      reactive_energy_pulse_reg <= cfg_reg.polarity ? reactive_active : !reactive_active;
    end
  end

  tx_carrier_gen #(
    .PERIOD(CARRIER_PERIOD)
  ) carrier_gen (
    .clk(clk),
    .rst(rst),
    .duty(cfg_reg.duty),
    .carrier_reg(carrier)
  );

  always_comb begin
    case (cfg_reg.source)
      optical_pkg::SRC_UART: tx_src = uart_tx_data;
      optical_pkg::SRC_PIN_TWO: tx_src = general_pin_two_out;
      optical_pkg::SRC_REAL: tx_src = real_energy_pulse_reg;
      default: tx_src = reactive_energy_pulse_reg;
    endcase
    tx_inv = tx_src ^ cfg_reg.tx_invert;
    tx_next = (cfg_reg.tx_modulate && !tx_inv) ? carrier : tx_inv;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ir_transmit_pin_reg <= 1'b0;
    end else begin
      ir_transmit_pin_reg <= tx_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      uart_rx_data_reg <= 1'b1;
      general_pin_one_in_reg <= 1'b0;
    end else if (cfg_reg.rx_role) begin
      // uart idles high while the pin serves as a digital input
      uart_rx_data_reg <= 1'b1;
      general_pin_one_in_reg <= ir_receive_pin_level;
    end else begin
      uart_rx_data_reg <= ir_rx_comparator ^ cfg_reg.rx_invert;
      general_pin_one_in_reg <= 1'b0;
    end
  end

  always_comb begin
    rd_data = rd_data_reg;
    ir_transmit_pin = ir_transmit_pin_reg;
    real_energy_pulse = real_energy_pulse_reg;
    reactive_energy_pulse = reactive_energy_pulse_reg;
    uart_rx_data = uart_rx_data_reg;
    general_pin_one_in = general_pin_one_in_reg;
  end

endmodule : optical_port

/* File: test/optical_port_monitor.sv */
// Purpose: port-level checks for optical_port
// Assumes: config is shadowed from register writes seen on the bus
// Notes: pulse checks watch the real channel only, to keep the checker small
`timescale 1ns/1ps
module optical_port_monitor #(
  parameter int SAMPLE_CYCLES = 40
) (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic [15:0] addr, // address
  input wire logic [7:0] wr_data, // write data
  input wire logic wr_en, // write
  input wire logic rd_en, // read
  input wire logic [7:0] rd_data, // read data
  input wire logic uart_tx_data, // uart tx
  input wire logic general_pin_two_out, // pin two
  input wire logic real_pulse_req, // real req
  input wire logic ir_rx_comparator, // comparator
  input wire logic ir_receive_pin_level, // rx level
  input wire logic ir_transmit_pin, // tx pin
  input wire logic real_energy_pulse, // real pin
  input wire logic reactive_energy_pulse, // reactive pin
  input wire logic uart_rx_data, // uart rx
  input wire logic general_pin_one_in // pin one
);
  logic [7:0] txc_reg, ctl_reg, width_reg, unit_reg;
  logic pol_reg;
  logic tx_raw;
  int act_cnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      txc_reg <= 8'h00;
      ctl_reg <= 8'h00;
      width_reg <= 8'hff;
      unit_reg <= 8'h00;
      pol_reg <= 1'b0;
    end else if (wr_en) begin
      if (addr == optical_pkg::TX_CFG_ADDR) txc_reg <= wr_data;
      if (addr == optical_pkg::OPT_CTL_ADDR) ctl_reg <= wr_data;
      if (addr == optical_pkg::WIDTH_ADDR) width_reg <= wr_data;
      if (addr == optical_pkg::UNIT_ADDR) unit_reg <= wr_data;
      if (addr == optical_pkg::PLS_CTL_ADDR) pol_reg <= wr_data[6];
    end
  end
  // restart on request or config write, since a restart is legal in bypass
  always_ff @(posedge clk) begin
    if (rst || wr_en || real_pulse_req || real_energy_pulse != pol_reg) act_cnt <= 0;
    else act_cnt <= act_cnt + 1;
  end
  always_comb begin
    case (txc_reg[7:6])
      2'h0: tx_raw = uart_tx_data ^ ctl_reg[0];
      2'h1: tx_raw = general_pin_two_out ^ ctl_reg[0];
      2'h2: tx_raw = real_energy_pulse ^ ctl_reg[0];
      default: tx_raw = reactive_energy_pulse ^ ctl_reg[0];
    endcase
  end
  AST_TX_PATH: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && !$past(ctl_reg[1]) |-> ir_transmit_pin == $past(tx_raw))
    else $error("transmit pin differs from selected source");
  AST_TX_MOD_HIGH: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && $past(ctl_reg[1]) && $past(tx_raw) |-> ir_transmit_pin)
    else $error("high interval not passed under modulation");
  AST_RX_UART: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && !$past(ctl_reg[5])
    |-> uart_rx_data == ($past(ir_rx_comparator) ^ $past(ctl_reg[4])) && !general_pin_one_in)
    else $error("uart receive path wrong");
  AST_RX_PIN: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && $past(ctl_reg[5])
    |-> uart_rx_data && general_pin_one_in == $past(ir_receive_pin_level))
    else $error("digital receive path wrong");
  AST_PULSE_START: assert property (@(posedge clk) disable iff (rst)
    unit_reg == 8'h00 && width_reg != 8'hff && real_pulse_req |-> ##2 real_energy_pulse == pol_reg)
    else $error("bypass pulse not emitted at once");
  AST_PULSE_MAX: assert property (@(posedge clk) disable iff (rst)
    unit_reg == 8'h00 && width_reg != 8'hff
    |-> act_cnt <= (2 * width_reg + 1) * SAMPLE_CYCLES + 3)
    else $error("pulse longer than width limit");
  AST_PULSE_TOGGLE: assert property (@(posedge clk) disable iff (rst)
    unit_reg == 8'h00 && width_reg == 8'hff && real_pulse_req
    |-> ##2 real_energy_pulse != $past(real_energy_pulse))
    else $error("pulse pin did not toggle");
  AST_RD_IDLE: assert property (@(posedge clk) disable iff (rst)
    !$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data outside its cycle");
endmodule : optical_port_monitor

bind optical_port optical_port_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) mon (
  .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .uart_tx_data(uart_tx_data), .general_pin_two_out(general_pin_two_out),
  .real_pulse_req(real_pulse_req), .ir_rx_comparator(ir_rx_comparator),
  .ir_receive_pin_level(ir_receive_pin_level), .ir_transmit_pin(ir_transmit_pin),
  .real_energy_pulse(real_energy_pulse), .reactive_energy_pulse(reactive_energy_pulse),
  .uart_rx_data(uart_rx_data), .general_pin_one_in(general_pin_one_in)
);

/* File: test/ir_front_end.sv */
// Purpose: behavioural infrared emitter and detector at the port pins
// Assumes: the bench sets the light that a remote transmitter sends
// Notes: led counted as lit while the transmit pin is low
`timescale 1ns/1ps
module ir_front_end (
  input wire logic clk, // clock
  input wire logic clear, // restart led count
  input wire logic light, // remote light
  input wire logic ir_transmit_pin, // led drive
  output logic ir_rx_comparator, // detector via comparator
  output logic ir_receive_pin_level, // detector as digital level
  output int led_lows // lit cycles since clear
);
  assign ir_rx_comparator = light;
  assign ir_receive_pin_level = light;
  always @(posedge clk) begin
    if (clear) led_lows <= 0;
    else if (ir_transmit_pin === 1'b0) led_lows <= led_lows + 1;
  end
endmodule : ir_front_end

/* File: test/tb_top.sv */
// Purpose: self-checking bench for optical_port
// Assumes: sample period shortened to 40 cycles, carrier period 64
// Notes: the fifo spacing run dominates the run time
`timescale 1ns/1ps
module tb_top;
  localparam int SAMP = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic uart_tx = 1'b0;
  logic pin_two = 1'b0;
  logic real_req = 1'b0;
  logic react_req = 1'b0;
  logic light = 1'b0;
  logic clear = 1'b0;
  logic [7:0] rd_data, rv;
  logic comp, pin_lvl, tx_pin, real_pin, react_pin, urx, pin_one, prev;
  int led_lows, n, i, falls;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [21:0] rows [11];
  always #2.5 clk = ~clk;
  optical_port #(.SAMPLE_CYCLES(SAMP)) uut (.clk(clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .uart_tx_data(uart_tx), .general_pin_two_out(pin_two), .real_pulse_req(real_req),
    .reactive_pulse_req(react_req), .ir_rx_comparator(comp), .ir_receive_pin_level(pin_lvl),
    .ir_transmit_pin(tx_pin), .real_energy_pulse(real_pin), .reactive_energy_pulse(react_pin),
    .uart_rx_data(urx), .general_pin_one_in(pin_one));
  ir_front_end fe (.clk(clk), .clear(clear), .light(light), .ir_transmit_pin(tx_pin),
    .ir_rx_comparator(comp), .ir_receive_pin_level(pin_lvl), .led_lows(led_lows));
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", what, e, g);
    end
  endtask : check
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check("read data", {24'h0, e}, {24'h0, rd_data});
  endtask : rdc
  task automatic fire;
    @(posedge clk);
    real_req <= 1'b1;
    react_req <= 1'b1;
    @(posedge clk);
    real_req <= 1'b0;
    react_req <= 1'b0;
  endtask : fire
  task automatic measure(input logic act, input int lo, input int hi);
    int len;
    len = 0;
    for (i = 0; i < 3000 && (len == 0 || real_pin === act); i++) begin
      @(posedge clk);
      #1;
      if (real_pin === act) len++;
    end
    check("pulse length", 1, {31'h0, len > lo && len <= hi});
    if (i >= 3000) stop_test();
  endtask : measure
  task automatic duty_run(input logic [7:0] c, input logic [7:0] t, input logic u, input int e);
    wr(optical_pkg::OPT_CTL_ADDR, c);
    wr(optical_pkg::TX_CFG_ADDR, t);
    uart_tx <= u;
    repeat (3) @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    repeat (64) @(posedge clk);
    #1;
    check("carrier low count", e, led_lows);
  endtask : duty_run
  initial begin
    // ctl, tx cfg, {uart, pin two, light}, {tx pin, uart rx, pin one}
    rows = '{{8'h00, 8'h00, 3'b000, 3'b000}, {8'h00, 8'h00, 3'b101, 3'b110},
      {8'h00, 8'h40, 3'b100, 3'b000}, {8'h00, 8'h40, 3'b010, 3'b100},
      {8'h01, 8'h00, 3'b100, 3'b000}, {8'h10, 8'h00, 3'b001, 3'b000},
      {8'h10, 8'h00, 3'b000, 3'b010}, {8'h30, 8'h00, 3'b000, 3'b010},
      {8'h20, 8'h00, 3'b001, 3'b011}, {8'h01, 8'h80, 3'b000, 3'b000},
      {8'h00, 8'hc0, 3'b000, 3'b100}};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc(optical_pkg::PLS_CTL_ADDR, 8'h00);
    rdc(optical_pkg::TX_CFG_ADDR, 8'h00);
    rdc(optical_pkg::WIDTH_ADDR, 8'hff);
    rdc(optical_pkg::UNIT_ADDR, 8'h00);
    wr(optical_pkg::OPT_CTL_ADDR, 8'hff);
    rdc(optical_pkg::OPT_CTL_ADDR, 8'h33);
    wr(16'h2010, 8'h5a);
    rdc(16'h2010, 8'h00);
    $display("done: registers");
    for (n = 0; n < 11; n++) begin
      wr(optical_pkg::OPT_CTL_ADDR, rows[n][21:14]);
      wr(optical_pkg::TX_CFG_ADDR, rows[n][13:6]);
      uart_tx <= rows[n][5];
      pin_two <= rows[n][4];
      light <= rows[n][3];
      repeat (3) @(posedge clk);
      #1;
      check("tx pin", {31'h0, rows[n][2]}, {31'h0, tx_pin});
      check("uart rx", {31'h0, rows[n][1]}, {31'h0, urx});
      check("pin one", {31'h0, rows[n][0]}, {31'h0, pin_one});
    end
    $display("done: pin rows");
    for (n = 0; n < 4; n++) duty_run(8'h02, n[1:0], 1'b0, 64 >> (n + 1));
    duty_run(8'h02, 8'h00, 1'b1, 0);
    duty_run(8'h03, 8'h03, 1'b1, 4);
    $display("done: modulation");
    for (n = 0; n < 3; n++) begin
      wr(optical_pkg::WIDTH_ADDR, n[7:0]);
      fire();
      measure(1'b0, 2 * n * SAMP - 1, (2 * n + 1) * SAMP + 1);
    end
    wr(optical_pkg::WIDTH_ADDR, 8'h00);
    wr(optical_pkg::PLS_CTL_ADDR, 8'h40);
    repeat (3) @(posedge clk);
    #1;
    check("idle level flipped", 0, {31'h0, real_pin});
    fire();
    measure(1'b1, -1, SAMP + 1);
    wr(optical_pkg::PLS_CTL_ADDR, 8'h00);
    $display("done: width and polarity");
    wr(optical_pkg::WIDTH_ADDR, 8'hff);
    repeat (2) begin
      rv[0] = real_pin;
      rv[1] = react_pin;
      fire();
      repeat (2) @(posedge clk);
      #1;
      check("toggled pins", {30'h0, ~rv[1:0]}, {30'h0, react_pin, real_pin});
    end
    $display("done: toggle");
    wr(optical_pkg::WIDTH_ADDR, 8'h00);
    wr(optical_pkg::UNIT_ADDR, optical_pkg::FIFO_INTERVAL);
    fire();
    fire();
    falls = 0;
    prev = real_pin;
    for (i = 0; i < 70000 && falls < 2; i++) begin
      @(posedge clk);
      #1;
      if (prev === 1'b1 && real_pin === 1'b0) falls++;
      prev = real_pin;
    end
    check("spaced pulses", 2, falls);
    if (i >= 70000) stop_test();
    $display("done: fifo");
    wr(optical_pkg::WIDTH_ADDR, 8'h05);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(optical_pkg::WIDTH_ADDR, 8'hff);
    rdc(optical_pkg::UNIT_ADDR, 8'h00);
    rdc(optical_pkg::STATUS_ADDR, 8'h07);
    $display("done: reset");
    stop_test();
  end
endmodule : tb_top
